// ==== src/port4_chip_select.sv ====
// Port 4 general I/O and chip-select strobe logic with AHB-Lite registers
`timescale 1ns/1ps
`include "port4_cs_defs.svh"

// How it works
// RL1: Mode 00 makes the pin plain quasi-bidirectional I/O.
// RL2: Mode 01 makes the pin a read strobe on matching reads.
// RL3: Mode 10 makes the pin a write strobe on matching writes.
// RL4: Mode 11 makes the pin a strobe on matching reads and writes.
// RL5: Width 00 compares all sixteen address bits.
// RL6: Width 01 compares bits 15 to 1.
// RL7: Width 10 compares bits 15 to 2.
// RL8: Width 11 compares bits 15 to 8.
// RL9: Each pin has its own high and low base address bytes.
// RL10: Polarity bit 1 means strobe active high, 0 active low.
// RL11: Hold bit keeps address-latch and fetch strobes high in power-down.
// RL12: Read-path bit selects pins or latch for read-modify-write reads.
// RL13: Four I/O bits in 3..0 with pull-ups; upper bits read zero.
// RL14: Matching external data accesses drive the strobe with its polarity.
// RL15: I/O pins keep driving their data bits beside strobe pins.
// RL16: Strobe lasts exactly as long as the external bus strobe.
// RL17: Reset clears all mode, width and polarity fields.
module port4_chip_select (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire port4_cs_pkg::ext_bus_s ext_bus,
    input wire logic power_down,
    input wire logic core_ale,
    input wire logic core_fetch,
    input wire logic rmw_read,
    output logic [7:0] rmw_read_data,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic ale_pin,
    output logic program_fetch_strobe
);
    import port4_cs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] port4_pin01_config;
    logic [7:0] port4_pin23_config;
    logic [7:0] strobe_polarity_and_misc;
    logic [3:0] port4_pin_data;
    logic [7:0] base_reg [0:7];
    bus_state_e state;
    logic [7:0] data_index;
    logic [3:0] strobe_active;
    logic [3:0] cs_mode_pin;
    pin_config_s cfg [0:3];
    logic [7:0] read_word;
    logic [7:0] addr_index;
    logic take;

    assign addr_index = haddr[9:2];
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking: zero wait states
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= BUS_IDLE;
            data_index <= 8'h00;
        end
        else if (hready)
        begin
            if (take)
            begin
                state <= hwrite ? BUS_WRITE : BUS_READ;
                data_index <= addr_index;
            end
            else
            begin
                state <= BUS_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port4_pin01_config <= `CONFIG_RESET; // [RL17]
            port4_pin23_config <= `CONFIG_RESET; // [RL17]
            strobe_polarity_and_misc <= `POLARITY_RESET; // [RL17]
            port4_pin_data <= `DATA_RESET;
        end
        else if (state == BUS_WRITE)
        begin
            case (data_index)
                `IDX_PIN01_CONFIG: port4_pin01_config <= hwdata[7:0];
                `IDX_PIN23_CONFIG: port4_pin23_config <= hwdata[7:0];
                `IDX_POLARITY_MISC:
                    strobe_polarity_and_misc <= {hwdata[7:4], 2'b00,
                        hwdata[1:0]};
                `IDX_PIN_DATA: port4_pin_data <= hwdata[3:0]; // [RL13]
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 8; i++)
                base_reg[i] <= `BASE_RESET;
        end
        else if (state == BUS_WRITE && data_index >= `IDX_BASE_FIRST
                 && data_index <= `IDX_BASE_LAST)
        begin
            base_reg[3'(data_index - `IDX_BASE_FIRST)] <= hwdata[7:0]; // [RL9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux on the address phase; pin levels read back as data
    always_comb
    begin
        read_word = 8'h00;
        case (addr_index)
            `IDX_PIN01_CONFIG: read_word = port4_pin01_config;
            `IDX_PIN23_CONFIG: read_word = port4_pin23_config;
            `IDX_POLARITY_MISC: read_word = strobe_polarity_and_misc;
            `IDX_PIN_DATA: read_word = {4'h0, pin_in}; // [RL13]
            `IDX_CORE_STATUS: read_word = {4'h0, strobe_active};
            default:
            begin
                if (addr_index >= `IDX_BASE_FIRST
                    && addr_index <= `IDX_BASE_LAST)
                    read_word = base_reg[3'(addr_index - `IDX_BASE_FIRST)];
            end
        endcase
    end

    // Registered so read data stands clean for the whole data phase.
    // Limitation: a read right behind a write to the same register
    // returns the value from before that write.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hrdata <= 32'h00000000;
        end
        else if (hready)
        begin
            if (take && !hwrite)
                hrdata <= {24'h000000, read_word};
            else
                hrdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin compare and strobe generation
    assign cfg[0] = port4_pin01_config[3:0];
    assign cfg[1] = port4_pin01_config[7:4];
    assign cfg[2] = port4_pin23_config[3:0];
    assign cfg[3] = port4_pin23_config[7:4];

    always_comb
    begin
        logic [15:0] base;
        logic [15:0] mask;
        logic hit;
        base = 16'h0000;
        mask = 16'hFFFF;
        hit = 1'b0;
        for (int p = 0; p < 4; p++)
        begin
            base = {base_reg[2*p], base_reg[2*p+1]}; // [RL9]
            case (cfg[p].cmp_width)
                `CMP_FULL: mask = 16'hFFFF; // [RL5]
                `CMP_A15_A1: mask = 16'hFFFE; // [RL6]
                `CMP_A15_A2: mask = 16'hFFFC; // [RL7]
                `CMP_A15_A8: mask = 16'hFF00; // [RL8]
                default: mask = 16'hFFFF;
            endcase
            hit = ((ext_bus.addr ^ base) & mask) == 16'h0000;
            case (cfg[p].mode)
                `MODE_READ: strobe_active[p] = hit && ext_bus.rd_strobe; // [RL2]
                `MODE_WRITE: strobe_active[p] = hit && ext_bus.wr_strobe; // [RL3]
                `MODE_BOTH: // [RL4]
                    strobe_active[p] = hit
                        && (ext_bus.rd_strobe || ext_bus.wr_strobe);
                default: strobe_active[p] = 1'b0; // [RL1]
            endcase
            cs_mode_pin[p] = cfg[p].mode != `MODE_GPIO;
        end
    end

    // Combinational so the strobe tracks the bus strobe exactly
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            if (cs_mode_pin[p])
            begin
                // [RL10] [RL14] [RL16]
                pin_out[p] = strobe_active[p]
                    ~^ strobe_polarity_and_misc[`POL_FIELD_LSB + p];
                pin_oe_n[p] = 1'b0;
            end
            else
            begin
                // Quasi-bidirectional: drive low only, pull-up gives high
                pin_out[p] = port4_pin_data[p]; // [RL1] [RL15]
                pin_oe_n[p] = port4_pin_data[p]; // [RL13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down strobe hold and read-modify-write path
    always_comb
    begin
        if (power_down)
        begin
            ale_pin = strobe_polarity_and_misc[`PWDN_HOLD_BIT]; // [RL11]
            program_fetch_strobe = strobe_polarity_and_misc[`PWDN_HOLD_BIT];
        end
        else
        begin
            ale_pin = core_ale;
            program_fetch_strobe = core_fetch;
        end
    end

    always_comb
    begin
        rmw_read_data = 8'h00;
        if (rmw_read && strobe_polarity_and_misc[`RMW_PIN_BIT])
            rmw_read_data = {4'h0, pin_in}; // [RL12]
        else if (rmw_read)
            rmw_read_data = {4'h0, port4_pin_data}; // [RL12]
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks, all on the one core clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Exact address match hits under every compare width
    AST_WRITE_STROBE: assert property ( // [RL3]
        cfg[0].mode == `MODE_WRITE && ext_bus.wr_strobe
        && ext_bus.addr == {base_reg[0], base_reg[1]}
        |-> pin_out[0] == strobe_polarity_and_misc[4])
        else $error("pin0 write strobe not asserted");

    AST_READ_IGNORES_WRITE: assert property ( // [RL2]
        cfg[1].mode == `MODE_READ && !ext_bus.rd_strobe
        |-> pin_out[1] != strobe_polarity_and_misc[5])
        else $error("pin1 read strobe active without read");

    AST_GPIO_FOLLOW: assert property ( // [RL15]
        cfg[2].mode == `MODE_GPIO && state == BUS_WRITE
        && data_index == `IDX_PIN_DATA
        |=> pin_out[2] == $past(hwdata[2]))
        else $error("gpio pin2 did not follow data");

    AST_BOTH_DIR: assert property ( // [RL4] [RL16]
        cfg[3].mode == `MODE_BOTH && !ext_bus.rd_strobe
        && !ext_bus.wr_strobe
        |-> !strobe_active[3])
        else $error("pin3 strobe outside access");

    AST_BOTH_READ_HIT: assert property ( // [RL4]
        cfg[3].mode == `MODE_BOTH && ext_bus.rd_strobe
        && ext_bus.addr == {base_reg[6], base_reg[7]}
        |-> strobe_active[3])
        else $error("pin3 strobe missing on read");

    AST_HOLD: assert property ( // [RL11]
        power_down
        |-> ale_pin == strobe_polarity_and_misc[1]
        && program_fetch_strobe == ale_pin)
        else $error("power-down strobe hold wrong");

    AST_RMW: assert property ( // [RL12]
        rmw_read && !strobe_polarity_and_misc[0]
        |-> rmw_read_data[3:0] == port4_pin_data)
        else $error("rmw read path wrong");

    AST_RMW_PIN: assert property ( // [RL12]
        rmw_read && strobe_polarity_and_misc[0]
        |-> rmw_read_data[3:0] == pin_in)
        else $error("rmw pin read path wrong");

    AST_RESET_GPIO: assert property ( // [RL17]
        $rose(reset_n)
        |-> port4_pin01_config == 8'h00
        && port4_pin23_config == 8'h00)
        else $error("config not cleared at reset");

    AST_BYTE_WINDOW: assert property ( // [RL8]
        cfg[0].cmp_width == `CMP_A15_A8 && cfg[0].mode == `MODE_READ
        && ext_bus.rd_strobe && ext_bus.addr[15:8] != base_reg[0]
        |-> !strobe_active[0])
        else $error("pin0 matched outside window");

    AST_FULL_COMPARE: assert property ( // [RL5]
        cfg[3].cmp_width == `CMP_FULL && cfg[3].mode == `MODE_READ
        && ext_bus.addr != {base_reg[6], base_reg[7]}
        |-> !strobe_active[3])
        else $error("pin3 matched on partial address");

    AST_HALF_WINDOW: assert property ( // [RL6]
        cfg[1].cmp_width == `CMP_A15_A1 && cfg[1].mode == `MODE_READ
        && ext_bus.rd_strobe
        && ext_bus.addr[15:1] == {base_reg[2], base_reg[3][7:1]}
        |-> strobe_active[1])
        else $error("pin1 missed two-byte window");

    AST_QUAD_WINDOW: assert property ( // [RL7]
        cfg[2].cmp_width == `CMP_A15_A2 && cfg[2].mode == `MODE_WRITE
        && ext_bus.wr_strobe
        && ext_bus.addr[15:2] == {base_reg[4], base_reg[5][7:2]}
        |-> strobe_active[2])
        else $error("pin2 missed four-byte window");

    AST_POLARITY_LOW: assert property ( // [RL10]
        cs_mode_pin[0] && !strobe_polarity_and_misc[4]
        && !strobe_active[0]
        |-> pin_out[0])
        else $error("idle low-active strobe not high");

    AST_GPIO_OE: assert property ( // [RL1] [RL15]
        cfg[1].mode == `MODE_GPIO
        |-> pin_oe_n[1] == port4_pin_data[1]
        && pin_out[1] == port4_pin_data[1])
        else $error("gpio pin1 drive wrong");

    AST_STROBE_DRIVEN: assert property ( // [RL14]
        cfg[2].mode != `MODE_GPIO
        |-> !pin_oe_n[2])
        else $error("strobe pin2 not driven");

    AST_WRITE_LANDS: assert property ( // [RL9]
        state == BUS_WRITE && data_index == `IDX_BASE_FIRST
        |=> base_reg[0] == $past(hwdata[7:0]))
        else $error("base register write lost");

    AST_READ_IDLE: assert property ( // [RL13]
        state != BUS_READ
        |-> hrdata == 32'h00000000)
        else $error("read data outside data phase");

    COV_WRITE_HIT: cover property (strobe_active[0] && ext_bus.wr_strobe);
    COV_READ_HIT: cover property (strobe_active[1] && ext_bus.rd_strobe);
    COV_POWER_DOWN: cover property (power_down
        && strobe_polarity_and_misc[1]);
    COV_BOTH_HIT: cover property (strobe_active[3] && ext_bus.rd_strobe);
    COV_MIXED_PORT: cover property (cs_mode_pin[0] && !cs_mode_pin[1]);

endmodule : port4_chip_select

// ==== src/port4_cs_defs.svh ====
// Register offsets, field positions and reset values of the port 4 block
`ifndef PORT4_CS_DEFS_SVH
`define PORT4_CS_DEFS_SVH

// Printed offsets are not all word multiples: these are indexes
`define IDX_PIN01_CONFIG 8'h92
`define IDX_PIN23_CONFIG 8'h93
`define IDX_POLARITY_MISC 8'hA2
`define IDX_PIN_DATA 8'hA5
// Base address registers: index of pin0 high byte, then low, per pin
`define IDX_BASE_FIRST 8'hB0
`define IDX_BASE_LAST 8'hB7
`define IDX_CORE_STATUS 8'hB8

`define POL_FIELD_LSB 4
`define PWDN_HOLD_BIT 1
`define RMW_PIN_BIT 0

`define CONFIG_RESET 8'h00
`define POLARITY_RESET 8'h00
`define DATA_RESET 4'hF
`define BASE_RESET 8'h00

`define MODE_GPIO 2'b00
`define MODE_READ 2'b01
`define MODE_WRITE 2'b10
`define MODE_BOTH 2'b11
`define CMP_FULL 2'b00
`define CMP_A15_A1 2'b01
`define CMP_A15_A2 2'b10
`define CMP_A15_A8 2'b11

`endif

// ==== src/port4_cs_pkg.sv ====
// Types shared by the port 4 chip-select block
package port4_cs_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic rd_strobe;
        logic wr_strobe;
    } ext_bus_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] cmp_width;
    } pin_config_s;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } bus_state_e;

endpackage : port4_cs_pkg

// ==== verif/ext_periph_model.sv ====
// Far-side pins: resistive pull-ups plus optional external pull-downs
`timescale 1ns/1ps
module ext_periph_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] pull_low,
    output logic [3:0] pin_level
);
    ////////////////////////////////////////////////////////////////////////
    // Undriven pins float to the pull-up unless a peripheral sinks them
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            pin_level[p] = !pin_oe_n[p] ? pin_out[p] : !pull_low[p];
        end
    end
endmodule : ext_periph_model

// ==== verif/port_chip_select_strobe_tb.sv ====
// Self-checking bench for the port 4 chip-select block
`timescale 1ns/1ps
`include "port4_cs_defs.svh"
module port_chip_select_strobe_tb;
    import port4_cs_pkg::*;
    logic clk, reset_n, hsel, hwrite, hready, hresp, power_down;
    logic core_ale, core_fetch, rmw_read, ale_pin, program_fetch_strobe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] rmw_read_data, v;
    logic [3:0] pin_in, pin_out, pin_oe_n, pull_low, dat;
    ext_bus_s ext_bus;
    logic [1:0] mode [4];
    logic [1:0] wid [4];
    logic pol [4];
    logic [15:0] base [4];
    logic [15:0] a;
    int fails, checked, cycles, k;

    port4_chip_select i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .ext_bus(ext_bus),
        .power_down(power_down), .core_ale(core_ale),
        .core_fetch(core_fetch), .rmw_read(rmw_read),
        .rmw_read_data(rmw_read_data), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .ale_pin(ale_pin),
        .program_fetch_strobe(program_fetch_strobe));
    ext_periph_model i_far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pull_low(pull_low), .pin_level(pin_in));

    ////////////////////////////////////////////////////////////////////////
    task close_out;
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Idle cycle first so back-to-back calls never re-drive in one step
    task ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {22'h000000, idx, 2'b00};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge clk); while (hready !== 1'b1);
        v = hrdata[7:0];
    endtask : ahb

    task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        ahb(1'b0, idx, 8'h00);
        check(v, exp);
        check({7'h00, hresp}, 8'h00);
    endtask : rd_chk

    // Expected {oe_n, level} of all four pins for one bus state
    function automatic logic [7:0] exp_pins(logic [15:0] ad, logic r,
                                            logic w);
        logic [15:0] m;
        logic hit;
        logic [7:0] e;
        e = 8'h00;
        for (int p = 0; p < 4; p++)
        begin
            m = wid[p] == 2'b00 ? 16'hFFFF : wid[p] == 2'b01 ? 16'hFFFE :
                wid[p] == 2'b10 ? 16'hFFFC : 16'hFF00;
            hit = (((ad ^ base[p]) & m) == 16'h0000) &&
                  ((r && mode[p][0]) || (w && mode[p][1]));
            e[p] = mode[p] == 2'b00 ? dat[p] : (hit ~^ pol[p]);
            e[p + 4] = mode[p] == 2'b00 ? dat[p] : 1'b0;
        end
        return e;
    endfunction : exp_pins

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard: whole run needs only about a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; power_down = 1'b0;
        core_ale = 1'b0; core_fetch = 1'b0; rmw_read = 1'b0;
        pull_low = 4'h0; ext_bus = '0;
        void'($urandom(99));
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`IDX_PIN01_CONFIG, 8'h00);
        rd_chk(`IDX_PIN23_CONFIG, 8'h00);
        rd_chk(`IDX_POLARITY_MISC, 8'h00);
        rd_chk(`IDX_PIN_DATA, 8'h0F);
        rd_chk(8'h10, 8'h00);
        check({4'h0, pin_oe_n}, 8'h0F);
        ahb(1'b1, `IDX_POLARITY_MISC, 8'hFF);
        rd_chk(`IDX_POLARITY_MISC, 8'hF3);
        // Read path: latch stays 1, far side sinks pin 0
        ahb(1'b1, `IDX_PIN_DATA, 8'hFF);
        pull_low <= 4'h1;
        rmw_read <= 1'b1;
        rd_chk(`IDX_PIN_DATA, 8'h0E);
        check({4'h0, rmw_read_data[3:0]}, 8'h0E);
        ahb(1'b1, `IDX_POLARITY_MISC, 8'h00);
        @(negedge clk);
        check({4'h0, rmw_read_data[3:0]}, 8'h0F);
        pull_low <= 4'h0;
        for (int h = 0; h < 2; h++)
        begin
            ahb(1'b1, `IDX_POLARITY_MISC, {6'h00, h[0], 1'b0});
            power_down <= 1'b1;
            @(negedge clk);
            check({ale_pin, program_fetch_strobe}, {2{h[0]}});
            power_down <= 1'b0;
            core_ale <= 1'b1;
            @(negedge clk);
            check({ale_pin, program_fetch_strobe}, 8'h02);
            core_ale <= 1'b0;
        end
        for (int it = 0; it < 16; it++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                mode[p] = it < 4 ? it[1:0] : 2'($urandom);
                wid[p] = it < 4 ? it[1:0] : 2'($urandom);
                pol[p] = 1'($urandom);
                base[p] = 16'($urandom);
                ahb(1'b1, 8'(`IDX_BASE_FIRST + 2 * p), base[p][15:8]);
                ahb(1'b1, 8'(`IDX_BASE_FIRST + 2 * p + 1), base[p][7:0]);
            end
            rd_chk(8'hB5, base[2][7:0]);
            dat = 4'($urandom);
            ahb(1'b1, `IDX_PIN01_CONFIG, {mode[1], wid[1], mode[0], wid[0]});
            ahb(1'b1, `IDX_PIN23_CONFIG, {mode[3], wid[3], mode[2], wid[2]});
            ahb(1'b1, `IDX_POLARITY_MISC,
                {pol[3], pol[2], pol[1], pol[0], 4'h0});
            ahb(1'b1, `IDX_PIN_DATA, {4'h0, dat});
            for (int n = 0; n < 24; n++)
            begin
                k = $urandom % 20;
                a = base[$urandom % 4] ^ (k < 16 ? 16'h0001 << k : 16'h0000);
                k = $urandom % 3;
                @(posedge clk);
                ext_bus <= '{addr: a, rd_strobe: k == 1, wr_strobe: k == 2};
                @(negedge clk);
                check({pin_oe_n, pin_in}, exp_pins(a, k == 1, k == 2));
            end
            @(posedge clk);
            ext_bus <= '{addr: a, rd_strobe: 1'b0, wr_strobe: 1'b0};
            @(negedge clk);
            check({pin_oe_n, pin_in}, exp_pins(a, 1'b0, 1'b0));
        end
        close_out();
    end
endmodule : port_chip_select_strobe_tb
